// ---- include/cwg_pkg.sv ----
package cwg_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] CWG_ADDR_CTRL0 = 6'h00;
    localparam logic [5:0] CWG_ADDR_CTRL1 = 6'h04;
    localparam logic [5:0] CWG_ADDR_DBR = 6'h08;
    localparam logic [5:0] CWG_ADDR_DBF = 6'h0C;
    localparam logic [5:0] CWG_ADDR_CLKCTL = 6'h10;
    localparam logic [5:0] CWG_ADDR_INSEL = 6'h14;
    localparam logic [5:0] CWG_ADDR_STEER = 6'h18;
    localparam logic [5:0] CWG_ADDR_OUTEN = 6'h1C;
    localparam logic [5:0] CWG_ADDR_SDCTL = 6'h20;
    localparam logic [5:0] CWG_ADDR_SDSRC = 6'h24;

    // Field positions
    localparam int CWG_EN_BIT = 7;
    localparam int CWG_LD_BIT = 6;
    localparam int CWG_IN_BIT = 5;
    localparam int CWG_SD_BIT = 7;
    localparam int CWG_REN_BIT = 6;
    localparam int CWG_OVERRIDE_LEVEL_B_D_LSB = 4;
    localparam int CWG_OVERRIDE_LEVEL_A_C_LSB = 2;
    localparam int CWG_FIX_LSB = 4;

    // Widths and reset values
    localparam int CWG_DB_W = 6;
    localparam int CWG_NSYNC = 9;
    localparam logic [7:0] CWG_RST_BYTE = 8'h00;
    localparam logic [5:0] CWG_RST_DB = 6'h00;

    // Mode field codes
    typedef logic [2:0] cwg_mode_t;
    localparam cwg_mode_t CWG_MODE_STEER = 3'h0;
    localparam cwg_mode_t CWG_MODE_SSTEER = 3'h1;
    localparam cwg_mode_t CWG_MODE_FWD = 3'h2;
    localparam cwg_mode_t CWG_MODE_REV = 3'h3;
    localparam cwg_mode_t CWG_MODE_HALF = 3'h4;
    localparam cwg_mode_t CWG_MODE_PP = 3'h5;

    // Input select codes
    localparam logic [2:0] CWG_IN_PIN = 3'h0;
    localparam logic [2:0] CWG_IN_CMP1 = 3'h1;
    localparam logic [2:0] CWG_IN_CMP2 = 3'h2;
    localparam logic [2:0] CWG_IN_CAP1 = 3'h3;
    localparam logic [2:0] CWG_IN_CAP2 = 3'h4;

    // Synchroniser lane positions
    localparam int CWG_S_PIN = 0;
    localparam int CWG_S_CMP1 = 1;
    localparam int CWG_S_CMP2 = 2;
    localparam int CWG_S_CAP1 = 3;
    localparam int CWG_S_CAP2 = 4;
    localparam int CWG_S_TMR2 = 5;
    localparam int CWG_S_TMR4 = 6;
    localparam int CWG_S_TMR6 = 7;
    localparam int CWG_S_OSC = 8;

    // Override level codes
    localparam logic [1:0] CWG_OVR_RELEASE = 2'h1;
    localparam logic [1:0] CWG_OVR_HIGH = 2'h3;

endpackage : cwg_pkg

// ---- design/cwg_core.sv ----
`timescale 1ns/1ps
module cwg_core import cwg_pkg::*; #(
    parameter int DB_W = CWG_DB_W
) (
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous inputs
    input wire logic waveform_input_pin,
    input wire logic comparator_one_synced,
    input wire logic comparator_two_synced,
    input wire logic capture_unit_one_out,
    input wire logic capture_unit_two_out,
    input wire logic timer_two_postscaled,
    input wire logic timer_four_postscaled,
    input wire logic timer_six_postscaled,
    input wire logic internal_fast_oscillator,
    // Output pins A..D, bit 0 is A
    output logic [3:0] out_level,
    output logic [3:0] out_drive_n
);

    localparam logic [DB_W-1:0] DB_MAX = {DB_W{1'b1}};

    // Saturating dead-band count step
    function automatic logic [DB_W-1:0] sat_inc(input logic [DB_W-1:0] v);
        sat_inc = (v == DB_MAX) ? v : v + 1'b1;
    endfunction : sat_inc

    // Bus state
    logic wait_q;
    logic [31:0] rdata_q;
    // Software registers
    logic en_q, ld_q, cs_q, sd_bit_q, ren_q;
    cwg_mode_t mode_q;
    logic [3:0] pol_q, steer_q, fixed_q, oe_q;
    logic [DB_W-1:0] dbr_q, dbf_q, dbr_w_q, dbf_w_q;
    logic [2:0] isel_q;
    logic [1:0] override_level_b_d_q, override_level_a_c_q;
    logic [5:0] src_q;
    // Waveform state
    logic [CWG_NSYNC-1:0] sync1_q, sync2_q;
    logic osc_prev_q, data_q, dir_q, fb_pend_q, side_q, override_q;
    logic [3:0] steer_act_q, fixed_act_q;
    logic [DB_W-1:0] rise_cnt_q, fall_cnt_q;
    logic [3:0] level_q, drive_n_q;

    // Bus decode
    wire logic bus_req = avs_read | avs_write;
    wire logic wr_fire = avs_write & ~wait_q & avs_byteenable[0];
    wire logic [7:0] wb = avs_writedata[7:0];
    wire logic wr_ctrl0 = wr_fire & (avs_address == CWG_ADDR_CTRL0);
    wire logic wr_ctrl1 = wr_fire & (avs_address == CWG_ADDR_CTRL1);
    wire logic wr_dbr = wr_fire & (avs_address == CWG_ADDR_DBR);
    wire logic wr_dbf = wr_fire & (avs_address == CWG_ADDR_DBF);
    wire logic wr_clk = wr_fire & (avs_address == CWG_ADDR_CLKCTL);
    wire logic wr_isel = wr_fire & (avs_address == CWG_ADDR_INSEL);
    wire logic wr_steer = wr_fire & (avs_address == CWG_ADDR_STEER);
    wire logic wr_oe = wr_fire & (avs_address == CWG_ADDR_OUTEN);
    wire logic wr_sdc = wr_fire & (avs_address == CWG_ADDR_SDCTL);
    wire logic wr_src = wr_fire & (avs_address == CWG_ADDR_SDSRC);

    // Synchronised inputs, read only from the second stage
    wire logic [CWG_NSYNC-1:0] s = sync2_q;

    wire logic data_sel = (isel_q == CWG_IN_CMP1) ? s[CWG_S_CMP1] :
                          (isel_q == CWG_IN_CMP2) ? s[CWG_S_CMP2] :
                          (isel_q == CWG_IN_CAP1) ? s[CWG_S_CAP1] :
                          (isel_q == CWG_IN_CAP2) ? s[CWG_S_CAP2] : s[CWG_S_PIN];
    wire logic rise = data_sel & ~data_q;
    wire logic fall = ~data_sel & data_q;

    // dead-band tick from system clock or oscillator edge
    wire logic tick = cs_q ? (s[CWG_S_OSC] & ~osc_prev_q) : 1'b1;

    // active-low external sources, gated by selection
    wire logic [5:0] src_lvl = {s[CWG_S_PIN], s[CWG_S_TMR6], s[CWG_S_TMR4], s[CWG_S_TMR2],
                                s[CWG_S_CMP2], s[CWG_S_CMP1]};
    wire logic ext_sd = |(src_q & ~src_lvl);

    wire logic is_steer = (mode_q == CWG_MODE_STEER) | (mode_q == CWG_MODE_SSTEER);
    wire logic is_full = (mode_q == CWG_MODE_FWD) | (mode_q == CWG_MODE_REV);

    // direction sampled only at rising input edge
    wire logic dir_now = (rise & is_full) ? mode_q[0] : dir_q;
    wire logic side_now = rise ? ~side_q : side_q;

    // count reached; a zero value means no delay
    wire logic rise_done = rise_cnt_q >= dbr_w_q;
    wire logic fall_done = fall_cnt_q >= dbf_w_q;
    // reverse uses rising value, forward uses falling value; both timed from the rise
    wire logic fb_done = rise_cnt_q >= (dir_now ? dbr_w_q : dbf_w_q);
    // only the first pulse after a change is delayed, from its very first cycle
    wire logic fb_arm = rise & is_full & (mode_q[0] != dir_q);
    wire logic fb_mod = data_sel & (~(fb_pend_q | fb_arm) | fb_done);

    // immediate steering, steering latched at rise
    wire logic [3:0] steer_eff = (mode_q == CWG_MODE_STEER) ? steer_q : steer_act_q;
    wire logic [3:0] fixed_eff = (mode_q == CWG_MODE_STEER) ? fixed_q : fixed_act_q;

    // Raw active-sense waveform per output, before polarity
    logic [3:0] raw;
    logic [3:0] fixed;
    always_comb begin
        raw = 4'h0;
        fixed = 4'h0;
        case (mode_q)
            CWG_MODE_STEER, CWG_MODE_SSTEER: begin
                // steered outputs carry data, others hold fixed level
                raw = (steer_eff & {4{data_sel}}) | (~steer_eff & fixed_eff);
                fixed = ~steer_eff;
            end
            CWG_MODE_FWD, CWG_MODE_REV: begin
                // A and C static, B or D modulated
                raw = dir_now ? {1'b0, 1'b1, fb_mod, 1'b0} : {fb_mod, 1'b0, 1'b0, 1'b1};
            end
            CWG_MODE_HALF: begin
                // each leading edge waits out its dead band
                raw[0] = data_sel & rise_done;
                raw[1] = ~data_sel & fall_done;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            CWG_MODE_PP: begin
                raw[0] = data_sel & ~side_now;
                raw[1] = data_sel & side_now;
                raw[2] = raw[0];
                raw[3] = raw[1];
            end
            default: begin
                raw = 4'h0;
            end
        endcase
    end

    // polarity applies only to waveform outputs, not to fixed ones
    wire logic [3:0] wave = raw ^ (~pol_q & ~fixed);
    // shutdown touches steered or waveform outputs only
    wire logic [3:0] sd_hit = {4{override_q}} & ~fixed;
    // A/C from one field, B/D from the other; no polarity here
    wire logic [1:0] ovr_ac = override_level_a_c_q;
    wire logic [1:0] ovr_bd = override_level_b_d_q;
    wire logic [3:0] ovr_level = {ovr_bd == CWG_OVR_HIGH, ovr_ac == CWG_OVR_HIGH,
                                  ovr_bd == CWG_OVR_HIGH, ovr_ac == CWG_OVR_HIGH};
    wire logic [3:0] ovr_rel = {ovr_bd == CWG_OVR_RELEASE, ovr_ac == CWG_OVR_RELEASE,
                                ovr_bd == CWG_OVR_RELEASE, ovr_ac == CWG_OVR_RELEASE};
    wire logic [3:0] level_d = (sd_hit & ovr_level) | (~sd_hit & wave);
    // per-output enable, gated by module enable
    wire logic [3:0] drive_n_d = ~({4{en_q}} & oe_q & ~(sd_hit & ovr_rel));

    // Read mux
    wire logic [7:0] rd_mux =
        (avs_address == CWG_ADDR_CTRL0) ? {en_q, ld_q, 3'h0, mode_q} :
        (avs_address == CWG_ADDR_CTRL1) ? {2'h0, data_sel, 1'b0, pol_q} :
        (avs_address == CWG_ADDR_DBR) ? {2'h0, dbr_q} :
        (avs_address == CWG_ADDR_DBF) ? {2'h0, dbf_q} :
        (avs_address == CWG_ADDR_CLKCTL) ? {7'h00, cs_q} :
        (avs_address == CWG_ADDR_INSEL) ? {5'h00, isel_q} :
        (avs_address == CWG_ADDR_STEER) ? {fixed_q, steer_q} :
        (avs_address == CWG_ADDR_OUTEN) ? {4'h0, oe_q} :
        (avs_address == CWG_ADDR_SDCTL) ? {sd_bit_q, ren_q, override_level_b_d_q, override_level_a_c_q, 2'h0} :
        (avs_address == CWG_ADDR_SDSRC) ? {2'h0, src_q} : CWG_RST_BYTE;

    // Bus handshake: one wait cycle, answer registered
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            wait_q <= ~(bus_req & wait_q);
            if (avs_read & wait_q) begin
                rdata_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Input synchronisers, two stages each
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= {internal_fast_oscillator, timer_six_postscaled, timer_four_postscaled,
                        timer_two_postscaled, capture_unit_two_out, capture_unit_one_out,
                        comparator_two_synced, comparator_one_synced, waveform_input_pin};
            sync2_q <= sync1_q;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_q <= 1'b0;
            mode_q <= CWG_MODE_STEER;
            pol_q <= 4'h0;
            cs_q <= 1'b0;
            isel_q <= CWG_IN_PIN;
            {fixed_q, steer_q} <= CWG_RST_BYTE;
            oe_q <= 4'h0;
            {ren_q, override_level_b_d_q, override_level_a_c_q} <= 5'h00;
            src_q <= 6'h00;
            dbr_q <= CWG_RST_DB;
            dbf_q <= CWG_RST_DB;
        end else if (clk_en) begin
            if (wr_ctrl0) {en_q, mode_q} <= {wb[CWG_EN_BIT], wb[2:0]};
            if (wr_ctrl1) pol_q <= wb[3:0];
            if (wr_clk) cs_q <= wb[0];
            if (wr_isel) isel_q <= wb[2:0];
            if (wr_steer) {fixed_q, steer_q} <= wb;
            if (wr_oe) oe_q <= wb[3:0];
            if (wr_sdc) {ren_q, override_level_b_d_q, override_level_a_c_q} <= wb[CWG_REN_BIT:CWG_OVERRIDE_LEVEL_A_C_LSB];
            if (wr_src) src_q <= wb[5:0];
            if (wr_dbr) dbr_q <= wb[DB_W-1:0];
            if (wr_dbf) dbf_q <= wb[DB_W-1:0];
        end
    end

    // working dead-band copies and load request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ld_q <= 1'b0;
            dbr_w_q <= CWG_RST_DB;
            dbf_w_q <= CWG_RST_DB;
        end else if (clk_en) begin
            if (!en_q || (ld_q && fall)) begin
                dbr_w_q <= dbr_q;
                dbf_w_q <= dbf_q;
            end
            // Request only accepted once enabled; a new request beats the clear
            if (wr_ctrl0 && en_q && wb[CWG_LD_BIT]) ld_q <= 1'b1;
            else if (!en_q || fall) ld_q <= 1'b0;
        end
    end

    // two dead-band counters; short input never reaches the value
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rise_cnt_q <= '0;
            fall_cnt_q <= '0;
        end else if (clk_en) begin
            // counting starts on the sampled edge, so up to one tick of jitter
            rise_cnt_q <= !data_sel ? '0 : (tick ? sat_inc(rise_cnt_q) : rise_cnt_q);
            fall_cnt_q <= data_sel ? '0 : (tick ? sat_inc(fall_cnt_q) : fall_cnt_q);
        end
    end

    // Edge history, direction, push-pull side and steering latch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_q <= 1'b0;
            osc_prev_q <= 1'b0;
            dir_q <= 1'b0;
            fb_pend_q <= 1'b0;
            side_q <= 1'b1;
            steer_act_q <= 4'h0;
            fixed_act_q <= 4'h0;
        end else if (clk_en) begin
            data_q <= data_sel;
            osc_prev_q <= s[CWG_S_OSC];
            dir_q <= dir_now;
            // pending delay armed by a direction change at rise
            if (fb_arm) fb_pend_q <= 1'b1;
            else if (fall || !is_full) fb_pend_q <= 1'b0;
            side_q <= (!en_q || override_q) ? 1'b1 : side_now;
            if (mode_q == CWG_MODE_STEER || rise) begin
                steer_act_q <= steer_q;
                fixed_act_q <= fixed_q;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sd_bit_q <= 1'b0;
            override_q <= 1'b0;
        end else if (clk_en) begin
            // Hardware set wins over any software or auto clear
            if (ext_sd || (wr_sdc && wb[CWG_SD_BIT])) sd_bit_q <= 1'b1;
            else if (ren_q || (wr_sdc && !wb[CWG_SD_BIT])) sd_bit_q <= 1'b0;
            // Overrides hold until the first rise after the bit clears
            if (sd_bit_q || ext_sd) override_q <= 1'b1;
            else if (rise) override_q <= 1'b0;
        end
    end

    // Output flops; inactive and released after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_q <= 4'h0;
            drive_n_q <= 4'hF;
        end else if (clk_en) begin
            level_q <= level_d;
            drive_n_q <= drive_n_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign out_level = level_q;
    assign out_drive_n = drive_n_q;

    // Checks
    a_disabled_release: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !en_q) |=> (out_drive_n == 4'hF))
        else $error("outputs driven while module disabled");
    a_ext_sd_override: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && ext_sd) |=> ##1 (!clk_en || override_q))
        else $error("external shutdown did not force overrides");
    a_sd_level_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (ext_sd && clk_en) |=> sd_bit_q)
        else $error("shutdown bit clear while source active");
    a_sw_sd_persist: assert property (@(posedge clock) disable iff (sys_rst)
        (sd_bit_q && !ren_q && !wr_sdc && clk_en) |=> sd_bit_q)
        else $error("shutdown bit cleared without software");
    a_auto_restart: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && ren_q && !ext_sd && !wr_sdc) |=> !sd_bit_q)
        else $error("auto-restart did not clear shutdown bit");
    a_ovr_until_rise: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && override_q && !rise) |=> override_q)
        else $error("override released without a rising edge");
    a_db_load_gate: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && en_q && !(ld_q && fall)) |=> $stable(dbr_w_q) && $stable(dbf_w_q))
        else $error("working dead band changed outside load point");
    a_half_no_overlap: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && mode_q == CWG_MODE_HALF && !override_q) |=>
        (((out_level ~^ $past(pol_q)) & 4'h3) != 4'h3))
        else $error("half-bridge outputs overlap");
    a_sync_steer_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && mode_q == CWG_MODE_SSTEER && !rise) |=> $stable(steer_act_q) && $stable(fixed_act_q))
        else $error("synchronous steering changed without rise");
    a_ovr_no_pol: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && sd_hit[0]) |=> (out_level[0] == ($past(override_level_a_c_q) == CWG_OVR_HIGH)))
        else $error("override level altered");
    a_short_pulse: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && mode_q == CWG_MODE_HALF && !override_q && rise_cnt_q < dbr_w_q) |=>
        (((out_level ^ $past(pol_q)) & 4'h1) == 4'h1))
        else $error("pulse before dead band elapsed");

endmodule : cwg_core

// ---- tb/cwg_switch_model.sv ----
`timescale 1ns/1ps
// Gate driver stage with a pull-down on every gate input
module cwg_switch_model (
    // Clock and watch control
    input wire logic clock,
    input wire logic watch,
    // Pins from the block
    input wire logic [3:0] out_level,
    input wire logic [3:0] out_drive_n,
    // Gate levels and fault flag
    output logic [3:0] gate,
    output logic overlap_q
);
    // Released pins fall to the pull-down, never keep the last level
    assign gate = ~out_drive_n & out_level;
    initial overlap_q = 1'b0;
    always @(posedge clock) begin
        if (watch && gate[0] && gate[1]) begin
            overlap_q <= 1'b1;
        end
    end
endmodule : cwg_switch_model

// ---- tb/complementary_waveform_generator_bench.sv ----
`timescale 1ns/1ps
module complementary_waveform_generator_bench import cwg_pkg::*;;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic inp = 1'b0;
    logic [7:0] src = 8'hFE;
    logic [2:0] osc_cnt = 3'h0;
    logic [3:0] out_level, out_drive_n, gate;
    logic watch = 1'b0;
    logic overlap_q;
    logic [39:0] exp_q[$];
    int n_mismatch = 0;
    int checks = 0;
    int seed = 32'h7d89;
    logic [31:0] v;
    event pin_ev;
    // Clock and a free oscillator near 16 MHz
    always #4 clock = ~clock;
    always @(posedge clock) osc_cnt <= osc_cnt + 3'h1;
    cwg_core i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .waveform_input_pin(inp),
        .comparator_one_synced(src[1]), .comparator_two_synced(src[2]), .capture_unit_one_out(src[3]),
        .capture_unit_two_out(src[4]), .timer_two_postscaled(src[5]), .timer_four_postscaled(src[6]),
        .timer_six_postscaled(src[7]), .internal_fast_oscillator(osc_cnt[2]), .out_level(out_level),
        .out_drive_n(out_drive_n));
    cwg_switch_model i_sw (.clock(clock), .watch(watch), .out_level(out_level),
        .out_drive_n(out_drive_n), .gate(gate), .overlap_q(overlap_q));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // Oldest note against the result; low byte masked, upper bits exact
    task automatic cmp(input logic [31:0] got);
        logic [39:0] e;
        checks++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'hFF_FFFFFFFF;
        if (((got ^ e[31:0]) & {24'hFFFFFF, e[39:32]}) !== 32'h0) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, e[31:0]);
        end
    endtask : cmp
    // Result watchers: read answers and pin samples
    always @(posedge clock) if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata);
    always @(pin_ev) cmp({24'h0, out_drive_n, gate});
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // Avalon cycle held until waitrequest is sampled low
    task automatic rw(input logic [5:0] a, input logic w, input logic [7:0] d, e, m);
        @(posedge clock);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        if (!w) exp_q.push_back({m, 24'h0, e});
        // Only the watchdog ends a wait that never sees an answer
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : rw
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        rw(a, 1'b1, d, 8'h00, 8'h00);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e, m);
        rw(a, 1'b0, 8'h00, e, m);
    endtask : rd
    task automatic chk(input logic [7:0] e, m);
        exp_q.push_back({m, 24'h0, e});
        ->pin_ev;
    endtask : chk
    // High pulse, one pin sample inside it, then a quiet gap
    task automatic pw(input int hi, at, input logic [7:0] e, m);
        inp <= 1'b1;
        cyc(at);
        chk(e, m);
        cyc(hi - at);
        inp <= 1'b0;
        cyc(40);
    endtask : pw
    // Watchdog sized well beyond the sequence
    initial begin
        #(60000 * 8);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        cyc(16);
        sys_rst <= 1'b0;
        rd(CWG_ADDR_CTRL0, 8'h00, 8'hFF);
        rd(CWG_ADDR_SDCTL, 8'h00, 8'hFF);
        rd(CWG_ADDR_DBR, 8'h00, 8'h3F);
        rd(6'h3C, 8'h00, 8'hFF);
        chk(8'hF0, 8'hFF);
        wr(CWG_ADDR_OUTEN, 8'h0F);
        wr(CWG_ADDR_CTRL1, 8'h0F);
        wr(CWG_ADDR_STEER, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h80);
        pw(20, 10, 8'h0F, 8'hFF);
        chk(8'h00, 8'hFF);
        wr(CWG_ADDR_CTRL1, 8'h0E);
        cyc(6);
        chk(8'h01, 8'h0F);
        wr(CWG_ADDR_STEER, 8'hA0);
        cyc(4);
        chk(8'h0A, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h81);
        wr(CWG_ADDR_STEER, 8'h0F);
        cyc(6);
        chk(8'h0A, 8'h0F);
        pw(20, 10, 8'h0E, 8'h0F);
        // Each input source with a random level, others opposite
        for (int s = 0; s < 5; s++) begin
            v = $random(seed);
            wr(CWG_ADDR_INSEL, s[7:0]);
            inp <= ~v[0] ^ (s == 0);
            src[4:1] <= {4{~v[0]}} ^ (4'h1 << (s - 1));
            cyc(6);
            rd(CWG_ADDR_CTRL1, {2'h0, v[0], 5'h0}, 8'h20);
        end
        inp <= 1'b0;
        src[4:1] <= 4'hF;
        wr(CWG_ADDR_INSEL, 8'h00);
        wr(CWG_ADDR_CTRL1, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h00);
        cyc(4);
        chk(8'hF0, 8'hF0);
        wr(CWG_ADDR_DBR, 8'h0C);
        wr(CWG_ADDR_DBF, 8'h0C);
        wr(CWG_ADDR_CTRL0, 8'h84);
        watch <= 1'b1;
        pw(40, 12, 8'h00, 8'h01);
        pw(40, 30, 8'h05, 8'h0F);
        pw(8, 7, 8'h00, 8'h01);
        wr(CWG_ADDR_DBR, 8'h1E);
        pw(40, 24, 8'h01, 8'h01);
        wr(CWG_ADDR_CTRL0, 8'hC4);
        rd(CWG_ADDR_CTRL0, 8'hC4, 8'hFF);
        pw(40, 24, 8'h01, 8'h01);
        rd(CWG_ADDR_CTRL0, 8'h84, 8'hFF);
        pw(60, 24, 8'h00, 8'h01);
        checks++;
        if (overlap_q !== 1'b0) begin
            n_mismatch++;
            $display("[ERR] %0t outputs A and B overlapped", $time);
        end
        watch <= 1'b0;
        wr(CWG_ADDR_CLKCTL, 8'h01);
        pw(300, 100, 8'h00, 8'h01);
        cyc(120);
        wr(CWG_ADDR_CLKCTL, 8'h00);
        wr(CWG_ADDR_CTRL0, 8'h82);
        pw(80, 70, 8'h09, 8'h0F);
        inp <= 1'b1;
        wr(CWG_ADDR_CTRL0, 8'h83);
        cyc(6);
        chk(8'h09, 8'h0F);
        inp <= 1'b0;
        cyc(40);
        pw(80, 12, 8'h04, 8'h07);
        pw(80, 60, 8'h06, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h82);
        pw(80, 12, 8'h01, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h00);
        wr(CWG_ADDR_CTRL0, 8'h85);
        pw(80, 60, 8'h05, 8'h0F);
        pw(80, 60, 8'h0A, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h86);
        pw(80, 60, 8'h00, 8'h0F);
        wr(CWG_ADDR_CTRL0, 8'h84);
        wr(CWG_ADDR_CTRL1, 8'h00);
        wr(CWG_ADDR_SDCTL, 8'h8C);
        cyc(4);
        chk(8'h05, 8'h0F);
        rd(CWG_ADDR_SDCTL, 8'h8C, 8'hFF);
        wr(CWG_ADDR_SDCTL, 8'h0C);
        cyc(6);
        chk(8'h05, 8'h0F);
        pw(80, 60, 8'h0A, 8'h0F);
        wr(CWG_ADDR_SDSRC, 8'h01);
        src[1] <= 1'b0;
        cyc(6);
        chk(8'h05, 8'h0F);
        wr(CWG_ADDR_SDCTL, 8'h0C);
        rd(CWG_ADDR_SDCTL, 8'h80, 8'h80);
        wr(CWG_ADDR_SDCTL, 8'h4C);
        src[1] <= 1'b1;
        cyc(8);
        rd(CWG_ADDR_SDCTL, 8'h00, 8'h80);
        pw(80, 60, 8'h0A, 8'h0F);
        give_verdict();
    end
endmodule : complementary_waveform_generator_bench
